// file: hw/spi_master_slave_port.sv
// Function
// - Works as SPI master or slave, with separate slave-select input.
// - Comes out of reset as slave; other-role functions stay inactive.
// - Master-select bit switches role at run time.
// - Master serial clock comes from the system clock only.
// - Serial clock equals system clock divided by an integer divider.
// - Bit-order control picks LSB or MSB first, changeable at run time.
// - Polarity control sets the idle clock level, swapping the sampling and launching edges.
// - Phase control selects the alternate clock-to-data relationship.
// - Slave handshake sends a ready marker before readout data.
// - Master drives four slave selects chosen by the chip-select register.
// - Master can hold a select asserted across consecutive bytes.
// - Transmit-ready flag rises when the transmit register empties.
// - Receive-ready flag rises when new receive data is valid.
// - Slave-select low while master sets the mode-fault flag.
// - New byte while both receive buffer entries are unread sets the overrun flag.
// - Writing one clears a flag; writing zero leaves it.
// - Each of four interrupt sources has its own enable bit.
// - Wakeup enable lets the block assert its wakeup output.
// - Slave may shift out a status byte about its receive register.
// - Power-on reset returns port and all registers to reset state.
// - Eight-bit data toward the host, four-pin serial side.
// - Master select outputs are active low, one per slave.
`timescale 1ns/1ps
`default_nettype none

module spi_master_slave_port import spi_port_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Configuration
    input wire cfg_s controlRegs,
    input wire logic [3:0] chipSelectReg,
    input wire logic [3:0] interruptEnableReg,
    input wire logic [3:0] flagClearMask,
    // Transmit data
    input wire logic [7:0] txData,
    input wire logic txValid,
    output logic txReady,
    // Receive data
    output logic [7:0] receiveDataReg,
    output logic rxValid,
    input wire logic rxReady,
    // Status
    output logic [3:0] interruptFlagReg,
    output logic interruptRequestOut,
    output logic wakeupOut,
    // Serial pins
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOeN,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOeN,
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOeN,
    input wire logic slaveSelectInN,
    output logic [3:0] masterSelectOutN
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MASTER_XFER,
        ST_MASTER_HOLD,
        ST_SLAVE
    } state_e;

    state_e state;
    pins_s pins;
    logic roleMaster;
    logic [7:0] transmitDataReg;
    logic [7:0] txShift;
    logic [7:0] rxShift;
    logic [7:0] rxNext;
    logic [7:0] rxByte;
    logic [7:0] loadValue;
    logic [7:0] divCount;
    logic [7:0] effDiv;
    logic [7:0] halfDiv;
    logic [2:0] bitCount;
    logic lineOut;
    logic sckPrev;
    logic inMaster;
    logic masterLead;
    logic masterTrail;
    logic sckEdge;
    logic slaveLead;
    logic slaveTrail;
    logic leadEdge;
    logic trailEdge;
    logic sampleEdge;
    logic launchEdge;
    logic inBit;
    logic byteEnd;
    logic modeFault;
    logic startMaster;
    logic contMaster;
    logic startSlave;
    logic slaveNext;
    logic loadByte;
    logic takeTx;
    logic bufInReady;
    logic irqPending;
    logic [3:0] flagSet;
    logic [3:0] clearOnly;

    // ------------------------------------------------------------------
    // Input synchroniser and receive buffer
    // ------------------------------------------------------------------
    input_sync u_pinSync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .asyncIn({sckIn, mosiIn, misoIn, slaveSelectInN}),
        .syncOut(pins)
    );

    rx_two_entry_buffer u_rxBuffer (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .inData(rxByte),
        .inValid(byteEnd),
        .inReady(bufInReady),
        .outData(receiveDataReg),
        .outValid(rxValid),
        .outReady(rxReady)
    );

    // ------------------------------------------------------------------
    // Edge generation and decode
    // ------------------------------------------------------------------
    assign effDiv = (controlRegs.clkDivider < DIV_MIN) ? DIV_MIN : controlRegs.clkDivider;
    assign halfDiv = {1'b0, effDiv[7:1]};
    assign inMaster = (state == ST_MASTER_XFER);
    assign masterLead = inMaster && (divCount == halfDiv - 8'h01);
    assign masterTrail = inMaster && (divCount == effDiv - 8'h01);
    assign sckEdge = (pins.sck != sckPrev);
    assign slaveLead = (state == ST_SLAVE) && sckEdge
                       && (pins.sck != controlRegs.clockPolarityBit);
    assign slaveTrail = (state == ST_SLAVE) && sckEdge
                        && (pins.sck == controlRegs.clockPolarityBit);
    assign leadEdge = masterLead || slaveLead;
    assign trailEdge = masterTrail || slaveTrail;
    assign sampleEdge = controlRegs.clockPhaseBit ? trailEdge : leadEdge;
    assign launchEdge = controlRegs.clockPhaseBit ? leadEdge : trailEdge;
    assign inBit = roleMaster ? pins.miso : pins.mosi;
    assign rxNext = shiftIn(rxShift, inBit, controlRegs.lowBitFirst);
    assign rxByte = sampleEdge ? rxNext : rxShift;
    assign byteEnd = trailEdge && (bitCount == LAST_BIT);
    assign modeFault = roleMaster && !pins.ssn;

    // ------------------------------------------------------------------
    // Transfer start and continuation
    // ------------------------------------------------------------------
    assign startMaster = roleMaster && !modeFault && !txReady
                         && (state == ST_IDLE || state == ST_MASTER_HOLD);
    assign contMaster = inMaster && byteEnd && controlRegs.chipSelectHold
                        && !txReady && !modeFault;
    assign startSlave = (state == ST_IDLE) && !roleMaster && !pins.ssn;
    assign slaveNext = (state == ST_SLAVE) && byteEnd && !pins.ssn;
    assign loadByte = startMaster || contMaster || startSlave || slaveNext;

    always_comb begin
        loadValue = IDLE_FILL;
        takeTx = 1'b0;
        if (roleMaster) begin
            loadValue = transmitDataReg;
            takeTx = loadByte;
        end else if (startSlave && controlRegs.slaveHandshakeEnable) begin
            loadValue = txReady ? HANDSHAKE_WAIT : HANDSHAKE_READY;
        end else if (!txReady) begin
            loadValue = transmitDataReg;
            takeTx = loadByte;
        end else if (controlRegs.statusByteEnable) begin
            loadValue = {STATUS_PAD, interruptFlagReg[FLAG_RX_OVERRUN], rxValid};
        end
    end

    // ------------------------------------------------------------------
    // Role and state
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            roleMaster <= 1'b0;
        end else if (state == ST_IDLE) begin
            roleMaster <= controlRegs.masterSelectBit;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (startMaster) begin
                        state <= ST_MASTER_XFER;
                    end else if (startSlave) begin
                        state <= ST_SLAVE;
                    end
                end
                ST_MASTER_XFER: begin
                    if (modeFault) begin
                        state <= ST_IDLE;
                    end else if (byteEnd && !contMaster) begin
                        state <= controlRegs.chipSelectHold ? ST_MASTER_HOLD : ST_IDLE;
                    end
                end
                ST_MASTER_HOLD: begin
                    if (modeFault || !controlRegs.chipSelectHold) begin
                        state <= ST_IDLE;
                    end else if (startMaster) begin
                        state <= ST_MASTER_XFER;
                    end
                end
                ST_SLAVE: begin
                    if (pins.ssn) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Clock divider and bit counter
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            divCount <= BYTE_RESET;
        end else if (!inMaster || loadByte || masterTrail) begin
            divCount <= BYTE_RESET;
        end else begin
            divCount <= divCount + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bitCount <= 3'h0;
        end else if (loadByte || state == ST_IDLE) begin
            bitCount <= 3'h0;
        end else if (trailEdge) begin
            bitCount <= bitCount + 3'h1;
        end
    end

    // ------------------------------------------------------------------
    // Shift registers and transmit data register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            txShift <= BYTE_RESET;
            lineOut <= 1'b0;
        end else if (loadByte && controlRegs.clockPhaseBit) begin
            txShift <= loadValue;
        end else if (loadByte) begin
            lineOut <= pickBit(loadValue, controlRegs.lowBitFirst);
            txShift <= shiftOn(loadValue, controlRegs.lowBitFirst);
        end else if (launchEdge) begin
            lineOut <= pickBit(txShift, controlRegs.lowBitFirst);
            txShift <= shiftOn(txShift, controlRegs.lowBitFirst);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxShift <= BYTE_RESET;
        end else if (loadByte) begin
            rxShift <= BYTE_RESET;
        end else if (sampleEdge) begin
            rxShift <= rxNext;
        end
    end

    // Transmit register: txReady high means the register is empty.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            transmitDataReg <= BYTE_RESET;
            txReady <= 1'b1;
        end else if (takeTx) begin
            txReady <= 1'b1;
        end else if (txValid && txReady) begin
            transmitDataReg <= txData;
            txReady <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Master slave-select outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            masterSelectOutN <= SELECTS_IDLE;
        end else if (modeFault || (inMaster && byteEnd && !contMaster
                     && !controlRegs.chipSelectHold)
                     || (state == ST_MASTER_HOLD && !controlRegs.chipSelectHold)) begin
            masterSelectOutN <= SELECTS_IDLE;
        end else if (startMaster && state == ST_IDLE) begin
            masterSelectOutN <= ~chipSelectReg;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt flags, request and wakeup
    // ------------------------------------------------------------------
    always_comb begin
        flagSet = FLAGS_RESET;
        flagSet[FLAG_TX_READY] = takeTx;
        flagSet[FLAG_RX_READY] = byteEnd && bufInReady;
        flagSet[FLAG_MODE_FAULT] = modeFault;
        flagSet[FLAG_RX_OVERRUN] = byteEnd && !bufInReady;
    end

    assign clearOnly = flagClearMask & ~flagSet;
    assign irqPending = |(interruptFlagReg & interruptEnableReg);

    // A set arriving with its clear wins, so no event is lost.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            interruptFlagReg <= FLAGS_RESET;
        end else begin
            interruptFlagReg <= (interruptFlagReg & ~flagClearMask) | flagSet;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            interruptRequestOut <= 1'b0;
            wakeupOut <= 1'b0;
        end else begin
            interruptRequestOut <= irqPending;
            wakeupOut <= controlRegs.userWakeupEnable && !roleMaster && !pins.ssn;
        end
    end

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sckPrev <= 1'b0;
            sckOut <= 1'b0;
            sckOeN <= 1'b1;
            mosiOeN <= 1'b1;
            misoOeN <= 1'b1;
        end else begin
            sckPrev <= pins.sck;
            sckOeN <= !roleMaster;
            mosiOeN <= !roleMaster;
            misoOeN <= !(state == ST_SLAVE);
            if (!inMaster) begin
                sckOut <= controlRegs.clockPolarityBit;
            end else if (masterLead || masterTrail) begin
                sckOut <= !sckOut;
            end
        end
    end

    assign mosiOut = lineOut;
    assign misoOut = lineOut;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [4:0] sckToggles;
    logic [7:0] leadGap;
    logic sawLead;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sckToggles <= 5'h00;
            leadGap <= 8'h00;
            sawLead <= 1'b0;
        end else begin
            if (loadByte) begin
                sckToggles <= 5'h00;
            end else if (masterLead || masterTrail) begin
                sckToggles <= sckToggles + 5'h01;
            end
            leadGap <= masterLead ? 8'h01 : leadGap + 8'h01;
            if (!inMaster) begin
                sawLead <= 1'b0;
            end else if (masterLead) begin
                sawLead <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_overrun;
        byteEnd && !bufInReady;
    endsequence

    sequence s_hold_kept;
        state == ST_MASTER_HOLD && controlRegs.chipSelectHold && !modeFault;
    endsequence

    property p_role_frozen;
        state != ST_IDLE |=> $stable(roleMaster);
    endproperty
    a_role_frozen: assert property (p_role_frozen) else $error("role changed mid transfer");

    property p_clock_div;
        masterLead && sawLead |-> leadGap == effDiv;
    endproperty
    a_clock_div: assert property (p_clock_div) else $error("serial clock period wrong");

    property p_byte_len;
        inMaster && byteEnd |-> sckToggles == BYTE_TOGGLES;
    endproperty
    a_byte_len: assert property (p_byte_len) else $error("byte not sixteen edges");

    property p_hold;
        s_hold_kept |=> $stable(masterSelectOutN);
    endproperty
    a_hold: assert property (p_hold) else $error("select dropped during hold");

    property p_tx_ready;
        takeTx |=> txReady && interruptFlagReg[FLAG_TX_READY];
    endproperty
    a_tx_ready: assert property (p_tx_ready) else $error("tx ready not flagged");

    property p_rx_ready;
        byteEnd && bufInReady |=> rxValid && interruptFlagReg[FLAG_RX_READY];
    endproperty
    a_rx_ready: assert property (p_rx_ready) else $error("rx ready not flagged");

    property p_mode_fault;
        modeFault |=> interruptFlagReg[FLAG_MODE_FAULT] && masterSelectOutN == SELECTS_IDLE
                      && state != ST_MASTER_XFER;
    endproperty
    a_mode_fault: assert property (p_mode_fault) else $error("mode fault not handled");

    property p_overrun;
        s_overrun |=> interruptFlagReg[FLAG_RX_OVERRUN];
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_clear;
        1'b1 |=> (interruptFlagReg & $past(clearOnly)) == FLAGS_RESET;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared by one");

    property p_irq;
        1'b1 |=> interruptRequestOut == $past(irqPending);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt gating wrong");

endmodule : spi_master_slave_port
`default_nettype wire

// file: hw/spi_port_pkg.sv
package spi_port_pkg;

    // ------------------------------------------------------------------
    // Sizes, flag positions and fixed values
    // ------------------------------------------------------------------
    localparam int SYS_CLK_HZ = 40000000;
    localparam int FLAG_COUNT = 4;
    localparam int FLAG_TX_READY = 0;
    localparam int FLAG_RX_READY = 1;
    localparam int FLAG_MODE_FAULT = 2;
    localparam int FLAG_RX_OVERRUN = 3;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [4:0] BYTE_TOGGLES = 5'h0F;
    localparam logic [7:0] DIV_MIN = 8'h02;
    localparam logic [7:0] HANDSHAKE_WAIT = 8'h00;
    localparam logic [7:0] HANDSHAKE_READY = 8'hA5;
    localparam logic [7:0] IDLE_FILL = 8'hFF;
    localparam logic [5:0] STATUS_PAD = 6'h00;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [3:0] SELECTS_IDLE = 4'hF;
    localparam logic [3:0] PINS_RESET = 4'h1;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic masterSelectBit;
        logic lowBitFirst;
        logic clockPolarityBit;
        logic clockPhaseBit;
        logic slaveHandshakeEnable;
        logic statusByteEnable;
        logic userWakeupEnable;
        logic chipSelectHold;
        logic [7:0] clkDivider;
    } cfg_s;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic ssn;
    } pins_s;

    // ------------------------------------------------------------------
    // Bit order helpers
    // ------------------------------------------------------------------
    function automatic logic pickBit(input logic [7:0] s, input logic lsbFirst);
        pickBit = lsbFirst ? s[0] : s[7];
    endfunction : pickBit

    function automatic logic [7:0] shiftOn(input logic [7:0] s, input logic lsbFirst);
        shiftOn = lsbFirst ? {1'b0, s[7:1]} : {s[6:0], 1'b0};
    endfunction : shiftOn

    function automatic logic [7:0] shiftIn(input logic [7:0] s, input logic b,
                                           input logic lsbFirst);
        shiftIn = lsbFirst ? {b, s[7:1]} : {s[6:0], b};
    endfunction : shiftIn

endpackage : spi_port_pkg

// file: hw/input_sync.sv
`timescale 1ns/1ps
`default_nettype none

module input_sync import spi_port_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Pins
    input wire logic [3:0] asyncIn,
    output pins_s syncOut
);

    logic [3:0] stageOne;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stageOne <= PINS_RESET;
            syncOut <= PINS_RESET;
        end else begin
            stageOne <= asyncIn;
            syncOut <= stageOne;
        end
    end

endmodule : input_sync
`default_nettype wire

// file: hw/rx_two_entry_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module rx_two_entry_buffer import spi_port_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Fill side
    input wire logic [7:0] inData,
    input wire logic inValid,
    output logic inReady,
    // Drain side
    output logic [7:0] outData,
    output logic outValid,
    input wire logic outReady
);

    logic [7:0] tailData;
    logic tailValid;
    logic push;
    logic pop;

    assign inReady = !tailValid;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            outData <= BYTE_RESET;
            outValid <= 1'b0;
            tailData <= BYTE_RESET;
            tailValid <= 1'b0;
        end else if (pop && tailValid) begin
            outData <= tailData;
            tailData <= inData;
            tailValid <= push;
        end else if (pop) begin
            outData <= inData;
            outValid <= push;
        end else if (push && !outValid) begin
            outData <= inData;
            outValid <= 1'b1;
        end else if (push) begin
            tailData <= inData;
            tailValid <= 1'b1;
        end
    end

endmodule : rx_two_entry_buffer
`default_nettype wire

// file: verif/spi_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module spi_slave_model (
    // Serial side
    input wire logic sck,
    input wire logic mosi,
    input wire logic selN,
    output logic miso,
    // Bench side
    input wire logic [7:0] reply,
    output logic [7:0] got
);
    int n = 0;
    initial miso = 1'b0;
    // A released line shows the inverse of its last value, so no stale bit passes.
    always @(selN) begin
        n = 0;
        miso = selN ? ~miso : reply[7];
    end
    always @(posedge sck) if (!selN) begin
        got = {got[6:0], mosi};
        n = n + 1;
    end
    always @(negedge sck) if (!selN && n < 8) miso = reply[7 - n];
endmodule : spi_slave_model

`default_nettype wire

// file: verif/test_spi_master_slave_port.sv
`timescale 1ns/1ps
`default_nettype none

module test_spi_master_slave_port import spi_port_pkg::*;;
    logic sys_clk = 0, arst_n = 0, txValid = 0, rxReady = 0, ssn = 1;
    cfg_s cfg = '0;
    logic [3:0] cs = 4'h1, ien = 4'h0, clr = 4'h0, flags, mcs;
    logic [7:0] txData = 8'h00, reply = 8'h00, rxd, got;
    logic txReady, rxValid, irq, wake, sckO, sckOe, mosiO, mosiOe, misoO, misoOe, mMiso;
    int errTotal = 0, checksDone = 0, cycles = 0;
    wire logic sck = sckOe ? 1'b0 : sckO;
    wire logic mosi = mosiOe ? 1'b0 : mosiO;
    wire logic miso = misoOe ? mMiso : misoO;

    spi_master_slave_port dut (.sys_clk(sys_clk), .arst_n(arst_n), .controlRegs(cfg),
        .chipSelectReg(cs), .interruptEnableReg(ien), .flagClearMask(clr), .txData(txData),
        .txValid(txValid), .txReady(txReady), .receiveDataReg(rxd), .rxValid(rxValid),
        .rxReady(rxReady), .interruptFlagReg(flags), .interruptRequestOut(irq),
        .wakeupOut(wake), .sckIn(sck), .sckOut(sckO), .sckOeN(sckOe), .mosiIn(mosi),
        .mosiOut(mosiO), .mosiOeN(mosiOe), .misoIn(miso), .misoOut(misoO),
        .misoOeN(misoOe), .slaveSelectInN(ssn), .masterSelectOutN(mcs));
    spi_slave_model slave (.sck(sck), .mosi(mosi), .selN(mcs[0]), .miso(mMiso),
        .reply(reply), .got(got));

    initial forever #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errTotal++;
            conclude();
        end
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : tick

    function automatic logic [7:0] rev(input logic [7:0] v);
        for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
    endfunction : rev

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic resetWake;
        check({7'h0, txReady}, 8'h01);
        check({4'h0, mcs}, 8'h0F);
        check({7'h0, sckOe}, 8'h01);
        cfg = cfg_s'(16'h0200);
        ssn = 1'b0;
        tick(6);
        check({7'h0, wake}, 8'h01);
        check({7'h0, misoOe}, 8'h00);
        ssn = 1'b1;
        tick(6);
        check({7'h0, wake}, 8'h00);
        check({7'h0, misoOe}, 8'h01);
    endtask : resetWake

    task automatic xfer(input logic [7:0] b, input logic [3:0] sel, input logic lsb,
                        input logic [7:0] rep);
        reply = rep;
        cs = sel;
        ien = 4'h2;
        cfg = cfg_s'({1'b1, lsb, 6'h00, 8'h08});
        tick(2);
        txData = b;
        txValid = 1'b1;
        tick(1);
        txValid = 1'b0;
        tick(4);
        check({4'h0, mcs}, {4'h0, ~sel});
        check({7'h0, mosiOe}, 8'h00);
        for (int i = 0; i < 300 && rxValid !== 1'b1; i++) tick(1);
        check(rxd, lsb ? rev(rep) : rep);
        check(got, lsb ? rev(b) : b);
        tick(2);
        check({4'h0, flags}, 8'h03);
        check({7'h0, irq}, 8'h01);
        check({4'h0, mcs}, 8'h0F);
        rxReady = 1'b1;
        clr = 4'h1;
        tick(1);
        rxReady = 1'b0;
        clr = 4'h0;
        tick(2);
        check({4'h0, flags}, 8'h02);
        clr = 4'h2;
        tick(1);
        clr = 4'h0;
        tick(2);
        check({7'h0, irq}, 8'h00);
    endtask : xfer

    task automatic fault;
        ien = 4'h4;
        ssn = 1'b0;
        tick(8);
        check({7'h0, flags[2]}, 8'h01);
        check({7'h0, irq}, 8'h01);
        ssn = 1'b1;
        tick(4);
        clr = 4'h4;
        tick(1);
        clr = 4'h0;
        tick(2);
        check({7'h0, flags[2]}, 8'h00);
    endtask : fault

    initial begin
        tick(8);
        arst_n = 1'b1;
        tick(1);
        resetWake();
        xfer(8'hC5, 4'h1, 1'b0, 8'h3A);
        xfer(8'h96, 4'h9, 1'b1, 8'h61);
        fault();
        conclude();
    end
endmodule : test_spi_master_slave_port

`default_nettype wire
